// file: charger_status_pkg.sv
// Purpose: shared constants and carrier types for the charger status bank
// Assumes: 8-bit register space reached through the device's serial register port
// Notes: all status bits are live, read-only views of the charger's conditions
package charger_status_pkg;

  // register addresses
  localparam logic [7:0] TEMP_BOOST_STATUS_ADDR = 8'h1F;
  localparam logic [7:0] PROT_FAULT_STATUS_ADDR = 8'h20;

  // values after reset
  localparam logic [7:0] TEMP_BOOST_STATUS_RESET = 8'h00;
  localparam logic [7:0] PROT_FAULT_STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // temperature and boost status field positions
  localparam int unsigned BIT_BATTERY_LOW_FOR_BOOST = 4;
  localparam int unsigned BIT_THERMISTOR_BAND_COLD = 3;
  localparam int unsigned BIT_THERMISTOR_BAND_COOL = 2;
  localparam int unsigned BIT_THERMISTOR_BAND_WARM = 1;
  localparam int unsigned BIT_THERMISTOR_BAND_HOT = 0;
  localparam logic [2:0] TEMP_RESERVED_BITS = 3'h0;

  // protection fault status field positions
  localparam int unsigned BIT_DISCHARGE_CURRENT_REGULATING = 7;
  localparam int unsigned BIT_BUS_OVERVOLTAGE = 6;
  localparam int unsigned BIT_BATTERY_OVERVOLTAGE = 5;
  localparam int unsigned BIT_BUS_OVERCURRENT = 4;
  localparam int unsigned BIT_BATTERY_OVERCURRENT = 3;
  localparam int unsigned BIT_CONVERTER_OVERCURRENT = 2;
  localparam int unsigned BIT_INPUT_TWO_OVERVOLTAGE = 1;
  localparam int unsigned BIT_INPUT_ONE_OVERVOLTAGE = 0;

  // thermistor comparator outputs, one per threshold
  typedef struct packed {
    logic above_t5;
    logic above_t3;
    logic below_t2;
    logic below_t1;
  } therm_cmp_t;

  // conditions feeding the temperature and boost status register
  typedef struct packed {
    logic battery_low_for_boost;
    therm_cmp_t therm;
  } temp_cond_t;

  // conditions feeding the protection fault register, in bit order 7..0
  typedef struct packed {
    logic discharge_current_regulating;
    logic bus_overvoltage_active;
    logic battery_overvoltage_active;
    logic bus_overcurrent_active;
    logic battery_overcurrent_active;
    logic converter_overcurrent_active;
    logic input_two_overvoltage_active;
    logic input_one_overvoltage_active;
  } fault_cond_t;

  // register port request from the serial front end
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // register port answer
  typedef struct packed {
    logic valid;
    logic unmapped;
    logic [7:0] data;
  } reg_resp_t;

endpackage

// file: status_follow.sv
// Purpose: bank of status flops that track live condition inputs
// Assumes: conditions are synchronous to clk_sys
// Notes: no stickiness; each bit is one cycle behind its condition
`timescale 1ns/10ps
`default_nettype none
module status_follow #(
  parameter int unsigned WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // live conditions
  input wire logic [WIDTH-1:0] cond,
  // registered status
  output logic [WIDTH-1:0] status_r
);

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        status_r[i] <= RESET_VALUE[i];
      end else begin
        status_r[i] <= cond[i];
      end
    end
  end

endmodule
`default_nettype wire

// file: charger_fault_status_bank.sv
// Purpose: read-only temperature/boost and protection fault status registers
// Assumes: serial register port decodes frames and presents one-cycle requests
// Notes: bits follow live conditions; reads never clear anything
`timescale 1ns/10ps
`default_nettype none

module charger_fault_status_bank
  import charger_status_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // live conditions from the analog front end
  input wire temp_cond_t temp_cond,
  input wire fault_cond_t fault_cond,
  // register port from the serial front end
  input wire reg_req_t reg_req,
  output var reg_resp_t reg_resp_r,
  output logic write_ignored_r,
  // status views for the device's own flag logic
  output logic [7:0] temp_boost_status_r,
  output logic [7:0] protection_fault_status_r
);

  logic [7:0] temp_cond_bits;
  logic [7:0] read_mux;
  logic addr_hit;
  logic thermistor_band_cold;
  logic thermistor_band_cool;
  logic thermistor_band_warm;
  logic thermistor_band_hot;

  // band decode from threshold comparators; normal band between T2 and T3 sets none
  always_comb begin
    thermistor_band_cold = temp_cond.therm.below_t1;
    thermistor_band_cool = !temp_cond.therm.below_t1 && temp_cond.therm.below_t2;
    thermistor_band_warm = temp_cond.therm.above_t3 && !temp_cond.therm.above_t5;
    thermistor_band_hot = temp_cond.therm.above_t5;
  end

  always_comb begin
    temp_cond_bits = {TEMP_RESERVED_BITS, 5'h00};
    temp_cond_bits[BIT_BATTERY_LOW_FOR_BOOST] = temp_cond.battery_low_for_boost;
    temp_cond_bits[BIT_THERMISTOR_BAND_COLD] = thermistor_band_cold;
    temp_cond_bits[BIT_THERMISTOR_BAND_COOL] = thermistor_band_cool;
    temp_cond_bits[BIT_THERMISTOR_BAND_WARM] = thermistor_band_warm;
    temp_cond_bits[BIT_THERMISTOR_BAND_HOT] = thermistor_band_hot;
  end

  // live tracking: no latch, so a cleared condition clears its bit unaided
  status_follow #(
    .WIDTH(8),
    .RESET_VALUE(TEMP_BOOST_STATUS_RESET)
  ) u_temp_status (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .cond(temp_cond_bits),
    .status_r(temp_boost_status_r)
  );

  // struct field order matches the register's bit order
  status_follow #(
    .WIDTH(8),
    .RESET_VALUE(PROT_FAULT_STATUS_RESET)
  ) u_fault_status (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .cond(fault_cond),
    .status_r(protection_fault_status_r)
  );

  // address decode; unmapped addresses read as zero
  always_comb begin
    addr_hit = 1'b1;
    case (reg_req.addr)
      TEMP_BOOST_STATUS_ADDR: read_mux = temp_boost_status_r;
      PROT_FAULT_STATUS_ADDR: read_mux = protection_fault_status_r;
      default: begin
        read_mux = READ_ZERO;
        addr_hit = 1'b0;
      end
    endcase
  end

  // one-cycle read answer; a read beside a write is still served
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_resp_r <= '0;
    end else begin
      reg_resp_r.valid <= reg_req.rd;
      reg_resp_r.unmapped <= reg_req.rd && !addr_hit;
      reg_resp_r.data <= reg_req.rd ? read_mux : READ_ZERO;
    end
  end

  // writes have no path into the status flops, only this report
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      write_ignored_r <= 1'b0;
    end else begin
      write_ignored_r <= reg_req.wr;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic rd_temp;
  logic rd_fault;
  assign rd_temp = reg_req.rd && (reg_req.addr == TEMP_BOOST_STATUS_ADDR);
  assign rd_fault = reg_req.rd && (reg_req.addr == PROT_FAULT_STATUS_ADDR);

  chk_boost_low_read: assert property (
    rd_temp |=> reg_resp_r.valid &&
      reg_resp_r.data[4] == $past(temp_cond.battery_low_for_boost, 2))
    else $error("boost-low bit does not match battery condition");

  chk_cold_band_read: assert property (
    rd_temp |=> reg_resp_r.data[3] == $past(temp_cond.therm.below_t1, 2))
    else $error("cold band bit wrong");

  chk_cool_band_read: assert property (
    rd_temp |=> reg_resp_r.data[2] ==
      $past(!temp_cond.therm.below_t1 && temp_cond.therm.below_t2, 2))
    else $error("cool band bit wrong");

  chk_warm_band_read: assert property (
    rd_temp |=> reg_resp_r.data[1] ==
      $past(temp_cond.therm.above_t3 && !temp_cond.therm.above_t5, 2))
    else $error("warm band bit wrong");

  chk_hot_band_read: assert property (
    rd_temp |=> reg_resp_r.data[0] == $past(temp_cond.therm.above_t5, 2))
    else $error("hot band bit wrong");

  chk_temp_reset_zero: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    !reset_n |=> temp_boost_status_r == 8'h00 && !reg_resp_r.valid)
    else $error("temperature status not zero after reset");

  chk_fault_reset_zero: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    !reset_n |=> protection_fault_status_r == 8'h00 && reg_resp_r.data == 8'h00)
    else $error("fault status not zero after reset");

  chk_discharge_reg_read: assert property (
    rd_fault |=> reg_resp_r.data[7] ==
      $past(fault_cond.discharge_current_regulating, 2))
    else $error("discharge regulation bit wrong");

  chk_overvoltage_read: assert property (
    rd_fault |=>
      reg_resp_r.data[6] == $past(fault_cond.bus_overvoltage_active, 2) &&
      reg_resp_r.data[5] == $past(fault_cond.battery_overvoltage_active, 2) &&
      reg_resp_r.data[1] == $past(fault_cond.input_two_overvoltage_active, 2) &&
      reg_resp_r.data[0] == $past(fault_cond.input_one_overvoltage_active, 2))
    else $error("overvoltage bits wrong");

  chk_bus_overcurrent_read: assert property (
    rd_fault |=> reg_resp_r.data[4] == $past(fault_cond.bus_overcurrent_active, 2))
    else $error("bus overcurrent bit wrong");

  chk_batt_overcurrent_read: assert property (
    rd_fault |=> reg_resp_r.data[3] ==
      $past(fault_cond.battery_overcurrent_active, 2))
    else $error("battery overcurrent bit wrong");

  chk_conv_overcurrent_read: assert property (
    rd_fault |=> reg_resp_r.data[2] ==
      $past(fault_cond.converter_overcurrent_active, 2))
    else $error("converter overcurrent bit wrong");

  chk_reserved_bits_zero: assert property (
    rd_temp |=> reg_resp_r.data[7:5] == 3'h0)
    else $error("reserved temperature bits not zero");

  chk_write_no_effect: assert property (
    reg_req.wr |=> write_ignored_r &&
      protection_fault_status_r == $past(fault_cond) &&
      temp_boost_status_r[4] == $past(temp_cond.battery_low_for_boost))
    else $error("write disturbed a status register");

  chk_bit_self_clears: assert property (
    !fault_cond.bus_overvoltage_active && !reg_req.rd && !reg_req.wr
      ##1 !fault_cond.bus_overvoltage_active |=> !protection_fault_status_r[6])
    else $error("status bit held after condition ended");

  chk_unmapped_reads_zero: assert property (
    reg_req.rd && !addr_hit |=> reg_resp_r.unmapped && reg_resp_r.data == 8'h00)
    else $error("unmapped read returned data");

  // flat view of the fault conditions for per-bit checks
  logic [7:0] fault_cond_bits;
  assign fault_cond_bits = fault_cond;

  // answer timing on the register port
  chk_answer_needs_read: assert property (
    !reg_req.rd |=> !reg_resp_r.valid && !reg_resp_r.unmapped &&
      reg_resp_r.data == READ_ZERO)
    else $error("answer raised without a read");

  chk_read_answered: assert property (
    reg_req.rd |=> reg_resp_r.valid)
    else $error("read not answered in the next cycle");

  chk_mapped_read_flag: assert property (
    (rd_temp || rd_fault) |=> !reg_resp_r.unmapped)
    else $error("mapped read reported as unmapped");

  chk_unmapped_has_valid: assert property (
    reg_resp_r.unmapped |-> reg_resp_r.valid)
    else $error("unmapped flag without an answer");

  chk_write_pulse_only: assert property (
    !reg_req.wr |=> !write_ignored_r)
    else $error("write report without a write");

  chk_read_beside_write: assert property (
    reg_req.rd && reg_req.wr |=> reg_resp_r.valid && write_ignored_r)
    else $error("read beside a write not served");

  chk_answer_reset_quiet: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    !reset_n |=> !reg_resp_r.unmapped && !write_ignored_r)
    else $error("register port answer active after reset");

  // live status tracking, independent of reads
  chk_temp_tracks_cond: assert property (
    1'b1 |=> temp_boost_status_r[4] == $past(temp_cond.battery_low_for_boost) &&
      temp_boost_status_r[3] == $past(temp_cond.therm.below_t1) &&
      temp_boost_status_r[0] == $past(temp_cond.therm.above_t5))
    else $error("temperature status lags its conditions");

  chk_fault_tracks_cond: assert property (
    1'b1 |=> protection_fault_status_r == $past(fault_cond_bits))
    else $error("fault status lags its conditions");

  chk_boost_low_sets: assert property (
    !temp_boost_status_r[4] && temp_cond.battery_low_for_boost |=>
      temp_boost_status_r[4])
    else $error("boost-low bit missed a low battery");

  chk_boost_low_clears: assert property (
    temp_boost_status_r[4] && !temp_cond.battery_low_for_boost |=>
      !temp_boost_status_r[4])
    else $error("boost-low bit held after battery recovered");

  // each fault bit rises and falls one cycle after its condition
  for (genvar b = 0; b < $bits(fault_cond_t); b++) begin : g_fault_chk
    chk_fault_bit_sets: assert property (
      !protection_fault_status_r[b] && fault_cond_bits[b] |=>
        protection_fault_status_r[b])
      else $error("fault status bit missed a rising condition");

    chk_fault_bit_clears: assert property (
      protection_fault_status_r[b] && !fault_cond_bits[b] |=>
        !protection_fault_status_r[b])
      else $error("fault status bit held after its condition ended");
  end

  // band decode sanity on the registered view
  chk_reserved_status_zero: assert property (
    temp_boost_status_r[7:5] == 3'h0)
    else $error("reserved temperature status bits set");

  chk_cold_cool_apart: assert property (
    !(temp_boost_status_r[3] && temp_boost_status_r[2]))
    else $error("cold and cool bands both set");

  chk_warm_hot_apart: assert property (
    !(temp_boost_status_r[1] && temp_boost_status_r[0]))
    else $error("warm and hot bands both set");

  chk_cool_needs_t2: assert property (
    temp_boost_status_r[2] |-> $past(temp_cond.therm.below_t2))
    else $error("cool band set above threshold two");

  chk_cool_rejects_cold: assert property (
    temp_boost_status_r[2] |-> !$past(temp_cond.therm.below_t1))
    else $error("cool band set while colder than threshold one");

  chk_warm_needs_t3: assert property (
    temp_boost_status_r[1] |-> $past(temp_cond.therm.above_t3))
    else $error("warm band set below threshold three");

  cov_hot_read: cover property (rd_temp && temp_boost_status_r[0]);
  cov_fault_read_active: cover property (rd_fault ##1 reg_resp_r.data != 8'h00);
  cov_unmapped_read: cover property (reg_req.rd && !addr_hit);
  cov_write_ignored: cover property (reg_req.wr ##1 write_ignored_r);
  cov_read_beside_write: cover property (reg_req.rd && reg_req.wr);

endmodule
`default_nettype wire

// file: host_reg_model.sv
// Purpose: host side of the status register port
// Assumes: requests launch on the falling edge and last one cycle each
// Notes: answers are judged by the bench, this model only drives requests
`timescale 1ns/10ps
`default_nettype none
module host_reg_model
  import charger_status_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // request to the bank
  output var reg_req_t reg_req
);
  initial reg_req = '0;

  // calling twice in a row gives back-to-back requests
  task automatic access(input logic rd, input logic wr, input logic [7:0] addr,
                        input logic [7:0] wdata);
    @(negedge clk_sys);
    reg_req = '{rd: rd, wr: wr, addr: addr, wdata: wdata};
  endtask

  // released lines show the inverse so stale values never pass
  task automatic idle;
    @(negedge clk_sys);
    reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~reg_req.addr, wdata: ~reg_req.wdata};
  endtask
endmodule
`default_nettype wire

// file: charger_fault_status_bank_tb.sv
// Purpose: self-checking bench for the charger status bank
// Assumes: one-cycle read latency, conditions registered one cycle
// Notes: expected answers queue up at request time, a monitor pops them
`timescale 1ns/10ps
`default_nettype none
module charger_fault_status_bank_tb;
  import charger_status_pkg::*;
  logic clk_sys;
  logic reset_n;
  temp_cond_t temp_cond;
  fault_cond_t fault_cond;
  reg_req_t reg_req;
  reg_resp_t reg_resp_r;
  logic write_ignored_r;
  logic [7:0] temp_boost_status_r;
  logic [7:0] protection_fault_status_r;
  logic [8:0] exp_q[$];
  int n_errors;
  int n_tests;
  int cycles;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  charger_fault_status_bank u_dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .temp_cond(temp_cond),
    .fault_cond(fault_cond),
    .reg_req(reg_req),
    .reg_resp_r(reg_resp_r),
    .write_ignored_r(write_ignored_r),
    .temp_boost_status_r(temp_boost_status_r),
    .protection_fault_status_r(protection_fault_status_r)
  );

  host_reg_model u_host (
    .clk_sys(clk_sys),
    .reg_req(reg_req)
  );

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] temp_view(input temp_cond_t c);
    return {3'h0, c.battery_low_for_boost, c.therm.below_t1,
            ~c.therm.below_t1 & c.therm.below_t2, c.therm.above_t3 & ~c.therm.above_t5,
            c.therm.above_t5};
  endfunction

  // conditions must hold from the call through the next rising edge
  task automatic read_reg(input logic [7:0] addr);
    logic [8:0] e;
    e = (addr == TEMP_BOOST_STATUS_ADDR) ? {1'b0, temp_view(temp_cond)} :
        (addr == PROT_FAULT_STATUS_ADDR) ? {1'b0, fault_cond} : {1'b1, READ_ZERO};
    exp_q.push_back(e);
    u_host.access(1'b1, 1'b0, addr, 8'h00);
  endtask

  task automatic check_views;
    check("temp status", {1'b0, temp_boost_status_r}, {1'b0, temp_view(temp_cond)});
    check("fault status", {1'b0, protection_fault_status_r}, {1'b0, fault_cond});
  endtask

  task automatic check_reset_views;
    check("temp reset", {1'b0, temp_boost_status_r}, {1'b0, TEMP_BOOST_STATUS_RESET});
    check("fault reset", {1'b0, protection_fault_status_r}, {1'b0, PROT_FAULT_STATUS_RESET});
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    #1;
    if (reg_resp_r.valid === 1'b1) begin
      if (exp_q.size() == 0)
        check("unexpected answer", 9'h1FF, 9'h000);
      else
        check("read answer", {reg_resp_r.unmapped, reg_resp_r.data}, exp_q.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    reset_n = 1'b0;
    temp_cond = '0;
    fault_cond = '0;
    n_errors = 0;
    n_tests = 0;
    cycles = 0;
    void'($urandom(54063));
    repeat (2) @(negedge clk_sys);
    temp_cond = 5'h1F;
    fault_cond = 8'hFF;
    repeat (3) @(negedge clk_sys);
    check_reset_views();
    reset_n = 1'b1;
    // walk every band code, then random; walking fault bits shows self-clearing
    for (int i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      temp_cond = (i < 32) ? temp_cond_t'(i[4:0]) : temp_cond_t'(5'($urandom));
      fault_cond = (i < 8) ? (8'h01 << i) : 8'($urandom);
      read_reg(TEMP_BOOST_STATUS_ADDR);
      check_views();
      read_reg(PROT_FAULT_STATUS_ADDR);
      u_host.idle();
    end
    read_reg(8'h21);
    read_reg(8'h1E);
    // writes to both status registers change nothing
    for (int j = 0; j < 2; j++) begin
      u_host.access(1'b0, 1'b1, j ? PROT_FAULT_STATUS_ADDR : TEMP_BOOST_STATUS_ADDR, 8'hFF);
      u_host.idle();
      check("write pulse", {8'h00, write_ignored_r}, 9'h001);
      check_views();
    end
    // a read beside a write is served and the write still ignored
    exp_q.push_back({1'b0, fault_cond});
    u_host.access(1'b1, 1'b1, PROT_FAULT_STATUS_ADDR, 8'hFF);
    u_host.idle();
    check("write beside read", {8'h00, write_ignored_r}, 9'h001);
    check_views();
    @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    check_reset_views();
    reset_n = 1'b1;
    @(negedge clk_sys);
    read_reg(PROT_FAULT_STATUS_ADDR);
    u_host.idle();
    repeat (3) @(negedge clk_sys);
    check("answers left", 9'(exp_q.size()), 9'h000);
    check("write idle", {8'h00, write_ignored_r}, 9'h000);
    check("idle answer", {reg_resp_r.valid, reg_resp_r.data}, 9'h000);
    check("idle unmapped", {8'h00, reg_resp_r.unmapped}, 9'h000);
    summarize();
  end
endmodule
`default_nettype wire
